// *** rtl/scp_pkg.sv ***
// shared constants and types for the slave coprocessor port
package scp_pkg;
    // bus status codes
    localparam logic [3:0] BST_IDLE = 4'h0;
    localparam logic [3:0] BST_WAIT = 4'h3;
    localparam logic [3:0] BST_OPND = 4'hD;
    localparam logic [3:0] BST_STAT = 4'hE;
    localparam logic [3:0] BST_ID   = 4'hF;
    // trap vectors
    localparam logic [7:0] VEC_SLAVE = 8'h03;
    localparam logic [7:0] VEC_UND   = 8'h0A;
    // slave status word
    localparam int QUIT_BIT = 0;
    // register indices
    localparam logic [3:0] REG_CFG  = 4'h0;
    localparam logic [3:0] REG_IRQ  = 4'h1;
    localparam logic [3:0] REG_MASK = 4'h2;
    localparam logic [3:0] REG_PSW  = 4'h3;
    localparam logic [3:0] REG_SLV  = 4'h4;
    // instruction groups, also bit positions in the config register
    localparam logic [1:0] GRP_FPU = 2'h0;
    localparam logic [1:0] GRP_MMU = 2'h1;
    localparam logic [1:0] GRP_CUS = 2'h2;
    // irq status bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_SLV  = 1;
    localparam int IRQ_UND  = 2;
    // processor status word bits cleared on trap entry
    localparam int PSW_T = 1;
    localparam int PSW_U = 8;
    localparam int PSW_S = 9;
    localparam int PSW_P = 10;
    localparam logic [15:0] PSW_TRAP_CLR = 16'h0702;
    localparam logic [15:0] PSW_RST      = 16'h0000;
    localparam logic [2:0]  CFG_RST      = 3'h0;
    // operation word size fields
    localparam int OPW_SZ1 = 0;
    localparam int OPW_SZ2 = 2;
    localparam int OPW_RES = 4;

    typedef struct packed {
        logic [1:0]  group;
        logic [7:0]  id;
        logic [15:0] opword;
        logic        load_reg;
        logic [15:0] flag_mask;
    } scp_req_t;

    typedef struct packed {
        logic        valid;
        logic [7:0]  vector;
        logic [15:0] psw_push;
    } scp_trap_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } scp_sync_t;

    // 16-bit words for a size code: 0 none, 1 word, 2 double, 3 quad
    function automatic logic [3:0] scp_words(input logic [1:0] code);
        case (code)
            2'h0: scp_words = 4'h0;
            2'h1: scp_words = 4'h1;
            2'h2: scp_words = 4'h2;
            default: scp_words = 4'h4;
        endcase
    endfunction : scp_words
endpackage : scp_pkg

// *** rtl/scp_port.sv ***
// cpu side sequencer of the slave coprocessor exchange
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/100ps
`default_nettype none
// Operation
// - each slave group gated by config bit; else undefined trap, no bus
// - instruction basic field is id byte then 16-bit operation word
// - id byte on low bus lines with status 1111
// - operation word sent under status 1101
// - operation word travels byte swapped
// - operand count and sizes derived from operation word
// - cpu supplies each operand under status 1101, no extensions
// - while waiting with full queue, drive status 0011
// - after done pulse read status word, strobe on done line, 1110
// - quit bit set ends exchange with slave trap vector 3
// - selected status word flags loaded from slave status
// - results read under status 1101 and delivered
// - load register instructions end after last operand
// - trap entry restores, clears S U P T, pushes 16-bit word
module scp_port (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               rst,
    // register port
    input  wire logic [3:0]         reg_addr,
    input  wire logic [15:0]        reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic [15:0]             reg_rdata,
    output logic                    irq,
    // instruction request
    input  wire logic               req_valid,
    output logic                    req_ready,
    input  wire scp_pkg::scp_req_t  req,
    input  wire logic               queue_full,
    // operand stream
    input  wire logic               opnd_valid,
    output logic                    opnd_ready,
    input  wire logic [15:0]        opnd_data,
    // results
    output logic                    res_valid,
    output logic [15:0]             res_data,
    output scp_pkg::scp_trap_t      trap,
    output logic [15:0]             processor_status_word,
    // slave bus pins
    input  wire logic [15:0]        muxed_addr_data_bus_i,
    output logic [15:0]             muxed_addr_data_bus_o,
    output logic                    muxed_addr_data_bus_oe,
    output logic [3:0]              bus_status,
    output logic                    bus_read,
    input  wire logic               slave_done_strobe_i,
    output logic                    slave_done_strobe_o,
    output logic                    slave_done_strobe_oe
);
    typedef enum {S_IDLE, S_OPWORD, S_OPND, S_WAIT, S_STAT, S_RES, S_RCAP} scp_st_t;

    typedef struct packed {
        scp_st_t           st;
        scp_pkg::scp_req_t req;
        logic [3:0]        cnt;
        logic              done_seen;
        logic [2:0]        cfg;
        logic [2:0]        irq;
        logic [2:0]        mask;
        logic [15:0]       psw;
        logic [15:0]       psw_start;
        logic [15:0]       slv;
        logic [15:0]       bus_o;
        logic              bus_oe;
        logic [3:0]        bst;
        logic              bus_rd;
        logic              done_oe;
        logic [15:0]       rdata;
        logic              res_valid;
        logic [15:0]       res_data;
    } scp_port_t;

    scp_port_t   q, d;
    logic        done_fall;
    logic        trap_take;
    logic [7:0]  trap_vec;
    logic [15:0] psw_trap;
    logic [15:0] psw_base;
    logic [2:0]  ev;

    // an idle trap has no captured start word yet, so use the live one
    assign psw_base = (q.st == S_IDLE) ? q.psw : q.psw_start;

    // done line is asynchronous to clk
    scp_sync u_sync (
        .clk    (clk),
        .rst    (rst),
        .pin_i  (slave_done_strobe_i),
        .fall_o (done_fall)
    );

    scp_trap u_trap (
        .clk         (clk),
        .rst         (rst),
        .take_i      (trap_take),
        .vector_i    (trap_vec),
        .psw_start_i (psw_base),
        .psw_new_o   (psw_trap),
        .trap_o      (trap)
    );

    always_comb begin
        d           = q;
        ev          = 3'h0;
        trap_take   = 1'b0;
        trap_vec    = scp_pkg::VEC_UND;
        d.bus_oe    = 1'b0;
        d.bst       = scp_pkg::BST_IDLE;
        d.bus_rd    = 1'b0;
        d.done_oe   = 1'b0;
        d.res_valid = 1'b0;
        d.rdata     = 16'h0000;
        if (done_fall && q.st != S_IDLE) begin
            d.done_seen = 1'b1;
        end
        case (q.st)
            S_IDLE: begin
                if (req_valid) begin
                    d.req       = req;
                    d.psw_start = q.psw;
                    d.done_seen = 1'b0;
                    if (!q.cfg[req.group]) begin
                        trap_take    = 1'b1;
                        ev[scp_pkg::IRQ_UND] = 1'b1;
                        d.psw        = psw_trap;
                        d.psw_start  = q.psw;
                    end else begin
                        d.bus_o  = {8'h00, req.id};
                        d.bus_oe = 1'b1;
                        d.bst    = scp_pkg::BST_ID;
                        d.st     = S_OPWORD;
                    end
                end
            end
            S_OPWORD: begin
                d.bus_o  = {q.req.opword[7:0], q.req.opword[15:8]};
                d.bus_oe = 1'b1;
                d.bst    = scp_pkg::BST_OPND;
                // operand words from the size fields
                d.cnt    = scp_pkg::scp_words(q.req.opword[scp_pkg::OPW_SZ1 +: 2])
                         + scp_pkg::scp_words(q.req.opword[scp_pkg::OPW_SZ2 +: 2]);
                d.st     = S_OPND;
            end
            S_OPND: begin
                if (q.cnt == 4'h0) begin
                    if (q.req.load_reg) begin
                        ev[scp_pkg::IRQ_DONE] = 1'b1;
                        d.st = S_IDLE;
                    end else begin
                        d.st = S_WAIT;
                    end
                end else if (opnd_valid) begin
                    // operand fetched by the core, forwarded here
                    d.bus_o  = opnd_data;
                    d.bus_oe = 1'b1;
                    d.bst    = scp_pkg::BST_OPND;
                    d.cnt    = q.cnt - 4'h1;
                end
            end
            S_WAIT: begin
                // waiting status 0011 while the queue is full
                if (queue_full) begin
                    d.bst = scp_pkg::BST_WAIT;
                end
                // status read strobed by the done line
                if (q.done_seen || done_fall) begin
                    d.bst     = scp_pkg::BST_STAT;
                    d.done_oe = 1'b1;
                    d.st      = S_STAT;
                end
            end
            S_STAT: begin
                d.slv = muxed_addr_data_bus_i;
                if (muxed_addr_data_bus_i[scp_pkg::QUIT_BIT]) begin
                    trap_take = 1'b1;
                    trap_vec  = scp_pkg::VEC_SLAVE;
                    ev[scp_pkg::IRQ_SLV] = 1'b1;
                    // restore and clear status word bits
                    d.psw     = psw_trap;
                    d.st      = S_IDLE;
                end else begin
                    // masked flags taken from slave status
                    d.psw = (q.psw & ~q.req.flag_mask)
                          | (muxed_addr_data_bus_i & q.req.flag_mask);
                    d.cnt = scp_pkg::scp_words(q.req.opword[scp_pkg::OPW_RES +: 2]);
                    d.st  = S_RES;
                end
            end
            S_RES: begin
                if (q.cnt == 4'h0) begin
                    ev[scp_pkg::IRQ_DONE] = 1'b1;
                    d.st = S_IDLE;
                end else begin
                    d.bst    = scp_pkg::BST_OPND;
                    d.bus_rd = 1'b1;
                    d.st     = S_RCAP;
                end
            end
            S_RCAP: begin
                d.res_valid = 1'b1;
                d.res_data  = muxed_addr_data_bus_i;
                d.cnt       = q.cnt - 4'h1;
                d.st        = S_RES;
            end
            default: d.st = S_IDLE;
        endcase
        // software side; hardware status word updates win
        if (reg_wr) begin
            if (reg_addr == scp_pkg::REG_CFG) begin
                d.cfg = reg_wdata[2:0];
            end else if (reg_addr == scp_pkg::REG_IRQ) begin
                d.irq = q.irq & ~reg_wdata[2:0];
            end else if (reg_addr == scp_pkg::REG_MASK) begin
                d.mask = reg_wdata[2:0];
            end else if (reg_addr == scp_pkg::REG_PSW && d.psw == q.psw) begin
                d.psw = reg_wdata;
            end
        end
        // set wins over clear
        d.irq = d.irq | ev;
        if (reg_rd) begin
            if (reg_addr == scp_pkg::REG_CFG) begin
                d.rdata = {13'h0000, q.cfg};
            end else if (reg_addr == scp_pkg::REG_IRQ) begin
                d.rdata = {13'h0000, q.irq};
            end else if (reg_addr == scp_pkg::REG_MASK) begin
                d.rdata = {13'h0000, q.mask};
            end else if (reg_addr == scp_pkg::REG_PSW) begin
                d.rdata = q.psw;
            end else if (reg_addr == scp_pkg::REG_SLV) begin
                d.rdata = q.slv;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q     <= '0;
            q.st  <= S_IDLE;
            q.cfg <= scp_pkg::CFG_RST;
            q.psw <= scp_pkg::PSW_RST;
        end else begin
            q <= d;
        end
    end

    assign req_ready              = (q.st == S_IDLE);
    assign opnd_ready             = (q.st == S_OPND) && (q.cnt != 4'h0);
    assign reg_rdata              = q.rdata;
    assign irq                    = |(q.irq & q.mask);
    assign res_valid              = q.res_valid;
    assign res_data               = q.res_data;
    assign processor_status_word  = q.psw;
    assign muxed_addr_data_bus_o  = q.bus_o;
    assign muxed_addr_data_bus_oe = q.bus_oe;
    assign bus_status             = q.bst;
    assign bus_read               = q.bus_rd;
    // open drain: only ever pulls low
    assign slave_done_strobe_o    = 1'b0;
    assign slave_done_strobe_oe   = q.done_oe;

    // disabled group makes no bus activity
    chk_und_no_bus: assert property (@(posedge clk) disable iff (rst)
        req_valid && req_ready && !q.cfg[req.group]
        |=> !muxed_addr_data_bus_oe && trap.valid && trap.vector == scp_pkg::VEC_UND)
        else $error("disabled group touched the bus");
    chk_id_broadcast: assert property (@(posedge clk) disable iff (rst)
        req_valid && req_ready && q.cfg[req.group]
        |=> bus_status == scp_pkg::BST_ID && muxed_addr_data_bus_o == {8'h00, $past(req.id)})
        else $error("id not broadcast");
    // swapped operation word follows the id
    chk_opword_swap: assert property (@(posedge clk) disable iff (rst)
        bus_status == scp_pkg::BST_ID |=> bus_status == scp_pkg::BST_OPND
        && muxed_addr_data_bus_o == {q.req.opword[7:0], q.req.opword[15:8]})
        else $error("operation word not swapped");
    // accepted operand appears on the bus
    chk_opnd_issue: assert property (@(posedge clk) disable iff (rst)
        opnd_valid && opnd_ready |=> muxed_addr_data_bus_oe
        && bus_status == scp_pkg::BST_OPND && muxed_addr_data_bus_o == $past(opnd_data))
        else $error("operand not issued");
    // waiting status only with full queue
    chk_wait_status: assert property (@(posedge clk) disable iff (rst)
        bus_status == scp_pkg::BST_WAIT |-> $past(queue_full) && !muxed_addr_data_bus_oe)
        else $error("wait status without full queue");
    // status read drives done line low under 1110
    chk_stat_read: assert property (@(posedge clk) disable iff (rst)
        slave_done_strobe_oe |-> bus_status == scp_pkg::BST_STAT
        ##1 !slave_done_strobe_oe)
        else $error("status read malformed");
    // quit gives slave trap next cycle
    chk_quit_trap: assert property (@(posedge clk) disable iff (rst)
        slave_done_strobe_oe && muxed_addr_data_bus_i[scp_pkg::QUIT_BIT]
        |=> trap.valid && trap.vector == scp_pkg::VEC_SLAVE ##1 req_ready)
        else $error("quit did not trap");
    // trap clears S U P T and pushes the start word
    chk_trap_psw: assert property (@(posedge clk) disable iff (rst)
        trap.valid |-> (processor_status_word & scp_pkg::PSW_TRAP_CLR) == 16'h0000
        && trap.psw_push == q.psw_start)
        else $error("trap status word wrong");
    chk_load_nostat: assert property (@(posedge clk) disable iff (rst)
        q.req.load_reg && q.st != S_IDLE |-> !slave_done_strobe_oe)
        else $error("load register read status");
    // each read cycle yields one result word
    chk_result_read: assert property (@(posedge clk) disable iff (rst)
        bus_read |-> bus_status == scp_pkg::BST_OPND ##1 res_valid)
        else $error("result read lost");

    cov_und: cover property (@(posedge clk) disable iff (rst)
        trap.valid && trap.vector == scp_pkg::VEC_UND);
    cov_slave_trap: cover property (@(posedge clk) disable iff (rst)
        trap.valid && trap.vector == scp_pkg::VEC_SLAVE);
    cov_result: cover property (@(posedge clk) disable iff (rst) res_valid);
    cov_wait: cover property (@(posedge clk) disable iff (rst)
        bus_status == scp_pkg::BST_WAIT);
endmodule : scp_port
`default_nettype wire

// *** rtl/scp_sync.sv ***
// three-stage synchroniser with falling edge detect
`timescale 1ns/100ps
`default_nettype none
module scp_sync (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // pin and result
    input  wire logic pin_i,
    output logic      fall_o
);
    scp_pkg::scp_sync_t q, d;

    always_comb begin
        d     = q;
        d.s1  = pin_i;
        d.s2  = q.s1;
        d.s3  = q.s2;
        // glitch filter: a level counts once stages two and three agree
        if (q.s2 == q.s3) begin
            d.lvl = q.s3;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= 4'hF;
        end else begin
            q <= d;
        end
    end

    assign fall_o = q.lvl & ~d.lvl;
endmodule : scp_sync
`default_nettype wire

// *** rtl/scp_trap.sv ***
// trap entry: restored status word push and vector
`timescale 1ns/100ps
`default_nettype none
module scp_trap (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // request
    input  wire logic              take_i,
    input  wire logic [7:0]        vector_i,
    input  wire logic [15:0]       psw_start_i,
    // result
    output logic [15:0]            psw_new_o,
    output scp_pkg::scp_trap_t     trap_o
);
    scp_pkg::scp_trap_t q, d;

    always_comb begin
        d       = q;
        d.valid = 1'b0;
        if (take_i) begin
            d.valid    = 1'b1;
            d.vector   = vector_i;
            d.psw_push = psw_start_i;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign psw_new_o = psw_start_i & ~scp_pkg::PSW_TRAP_CLR;
    assign trap_o    = q;
endmodule : scp_trap
`default_nettype wire

// *** verification/scp_slave_model.sv ***
// behavioural slave processor on the far side of the coprocessor bus
`timescale 1ns/100ps
`default_nettype none
module scp_slave_model #(
    parameter logic [7:0] MY_ID = 8'hBE,
    parameter int         DLY   = 6
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // bus as seen by the slave
    input  wire logic [15:0] bus_o,
    input  wire logic        bus_oe,
    input  wire logic [3:0]  bus_status,
    input  wire logic        bus_read,
    input  wire logic        done_oe,
    output logic [15:0]      bus_i,
    output logic             done_pin,
    // scenario controls
    input  wire logic [15:0] stat_word,
    input  wire logic [15:0] result,
    input  wire logic        no_ack,
    output logic [15:0]      got_opword
);
    logic        active;
    logic        want_op;
    logic        pull_low;
    logic [3:0]  left;
    logic [7:0]  cnt;
    logic [15:0] last;
    function automatic logic [3:0] words(input logic [1:0] c);
        return (c == 2'h3) ? 4'h4 : {2'h0, c};
    endfunction : words
    // pull-up holds the line high unless someone sinks it
    assign done_pin = !(done_oe || pull_low);
    // released bus shows the inverse of the last value, not a stale copy
    assign bus_i = !active ? ~last : (bus_status == scp_pkg::BST_STAT) ? stat_word :
                   bus_read ? result : ~last;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            active     <= 1'b0;
            want_op    <= 1'b0;
            pull_low   <= 1'b0;
            left       <= 4'h0;
            cnt        <= 8'h0;
            last       <= 16'h0;
            got_opword <= 16'h0;
        end else begin
            last     <= bus_oe ? bus_o : bus_i;
            pull_low <= 1'b0;
            // only the selected slave, new id restarts
            if (bus_status == scp_pkg::BST_ID && bus_oe) begin
                active  <= (bus_o[7:0] == MY_ID);
                want_op <= (bus_o[7:0] == MY_ID);
                left    <= 4'h0;
                cnt     <= 8'h0;
            end else if (active && want_op && bus_status == scp_pkg::BST_OPND && bus_oe) begin
                got_opword <= {bus_o[7:0], bus_o[15:8]};
                left       <= words(bus_o[9:8]) + words(bus_o[11:10]);
                want_op    <= 1'b0;
            end else if (active && left != 4'h0 && bus_status == scp_pkg::BST_OPND && bus_oe) begin
                left <= left - 4'h1;
                if (left == 4'h1 && !no_ack)
                    cnt <= DLY[7:0];
            end else if (cnt != 8'h0) begin
                cnt      <= cnt - 8'h1;
                // one low pulse, two cycles so the synchroniser sees it
                pull_low <= (cnt <= 8'h2);
            end
        end
    end
endmodule : scp_slave_model
`default_nettype wire

// *** verification/tb_slave_coprocessor_protocol.sv ***
// self-checking bench for the slave coprocessor port
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; $display("wrong value at %0t: got %h exp %h", $time, (a), (b)); end end
module tb_slave_coprocessor_protocol;
    logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, irq, req_valid = 1'b0;
    logic req_ready, queue_full = 1'b0, opnd_valid = 1'b0, opnd_ready, res_valid;
    logic bus_oe, bus_read, done_pin, done_o, done_oe, no_ack = 1'b0;
    logic [3:0]  reg_addr = 4'h0, bus_status;
    logic [15:0] reg_wdata = 16'h0, reg_rdata, opnd_data = 16'h0, res_data, psw, bus_i, bus_o;
    logic [15:0] stat_word = 16'h0, result = 16'h5A3C, got_opword, d;
    scp_pkg::scp_req_t  req = '0;
    scp_pkg::scp_trap_t trap;
    int errors = 0, tests_run = 0, oe_cnt = 0, e_cnt = 0, rd_cnt = 0, k, n;
    always #5 clk = ~clk;
    always @(posedge clk) begin
        oe_cnt += bus_oe;
        e_cnt  += (bus_status == scp_pkg::BST_STAT);
        rd_cnt += bus_read;
    end
    scp_port dut_u (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
        .req_valid(req_valid), .req_ready(req_ready), .req(req), .queue_full(queue_full),
        .opnd_valid(opnd_valid), .opnd_ready(opnd_ready), .opnd_data(opnd_data),
        .res_valid(res_valid), .res_data(res_data), .trap(trap), .processor_status_word(psw),
        .muxed_addr_data_bus_i(bus_i), .muxed_addr_data_bus_o(bus_o),
        .muxed_addr_data_bus_oe(bus_oe), .bus_status(bus_status), .bus_read(bus_read),
        .slave_done_strobe_i(done_pin), .slave_done_strobe_o(done_o),
        .slave_done_strobe_oe(done_oe));
    scp_slave_model u_slave (.clk(clk), .rst(rst), .bus_o(bus_o), .bus_oe(bus_oe),
        .bus_status(bus_status), .bus_read(bus_read), .done_oe(done_oe), .bus_i(bus_i),
        .done_pin(done_pin), .stat_word(stat_word), .result(result), .no_ack(no_ack),
        .got_opword(got_opword));
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk);
        {reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask : rd
    task automatic issue(input logic [1:0] g, input logic [15:0] op, input logic l,
                         input logic [15:0] m);
        @(posedge clk);
        req <= '{group: g, id: 8'hBE, opword: op, load_reg: l, flag_mask: m};
        req_valid <= 1'b1;
        @(negedge clk);
        while (req_ready !== 1'b1) @(negedge clk);
        @(posedge clk);
        req_valid <= 1'b0;
        @(negedge clk);
    endtask : issue
    task automatic opnd(input logic [15:0] v);
        @(posedge clk);
        {opnd_valid, opnd_data} <= {1'b1, v};
        @(negedge clk);
        while (opnd_ready !== 1'b1) @(negedge clk);
        @(posedge clk);
        opnd_valid <= 1'b0;
        @(negedge clk);
    endtask : opnd
    task automatic wait_st(input logic [3:0] c, input int lim);
        for (n = 0; n < lim && bus_status !== c; n++) @(negedge clk);
    endtask : wait_st
    task automatic t_reset();
        rd(scp_pkg::REG_CFG);
        `CHK(d, 16'h0000)
        rd(4'hF);
        `CHK(d, 16'h0000)
        $display("test reset finished");
    endtask : t_reset
    task automatic t_undef();
        wr(scp_pkg::REG_MASK, 16'h0004);
        wr(scp_pkg::REG_PSW, 16'h0703);
        k = oe_cnt;
        issue(scp_pkg::GRP_CUS, 16'h0001, 1'b0, 16'h0);
        `CHK({trap.valid, trap.vector}, {1'b1, scp_pkg::VEC_UND})
        `CHK({trap.psw_push, psw}, {16'h0703, 16'h0001})
        repeat (8) @(negedge clk);
        `CHK(oe_cnt, k)
        `CHK(irq, 1'b1)
        wr(scp_pkg::REG_IRQ, 16'h0004);
        @(negedge clk);
        `CHK(irq, 1'b0)
        $display("test undefined finished");
    endtask : t_undef
    task automatic t_exchange();
        wr(scp_pkg::REG_CFG, 16'h0007);
        stat_word  = 16'h00A4;
        queue_full <= 1'b1;
        issue(scp_pkg::GRP_FPU, 16'hC319, 1'b0, 16'h00F0);
        `CHK({bus_status, bus_oe, bus_o[7:0]}, {scp_pkg::BST_ID, 1'b1, 8'hBE})
        @(negedge clk);
        `CHK({bus_status, bus_o}, {scp_pkg::BST_OPND, 16'h19C3})
        for (k = 0; k < 3; k++) begin
            opnd(16'h1111 << k);
            `CHK({bus_status, bus_o}, {scp_pkg::BST_OPND, 16'h1111 << k})
        end
        wait_st(scp_pkg::BST_WAIT, 4);
        `CHK({bus_status, opnd_ready}, {scp_pkg::BST_WAIT, 1'b0})
        `CHK(got_opword, 16'hC319)
        wait_st(scp_pkg::BST_STAT, 40);
        `CHK({bus_status, done_oe, done_o}, {scp_pkg::BST_STAT, 2'h2})
        wait_st(scp_pkg::BST_OPND, 4);
        `CHK(bus_read, 1'b1)
        @(negedge clk);
        `CHK({res_valid, res_data}, {1'b1, 16'h5A3C})
        `CHK(e_cnt, 1)
        rd(scp_pkg::REG_PSW);
        `CHK(d, 16'h00A1)
        $display("test exchange finished");
    endtask : t_exchange
    task automatic t_loadreg();
        no_ack = 1'b1;
        k = e_cnt;
        issue(scp_pkg::GRP_MMU, 16'h0002, 1'b1, 16'h0);
        @(negedge clk);
        opnd(16'h0123);
        opnd(16'h4567);
        repeat (20) @(negedge clk);
        `CHK({e_cnt, req_ready}, {k, 1'b1})
        $display("test load register finished");
    endtask : t_loadreg
    task automatic t_quit();
        no_ack    = 1'b0;
        stat_word = 16'h0001;
        wr(scp_pkg::REG_PSW, 16'h0703);
        k = rd_cnt;
        issue(scp_pkg::GRP_FPU, 16'h0011, 1'b0, 16'h0);
        @(negedge clk);
        opnd(16'h0AAA);
        for (n = 0; n < 40 && trap.valid !== 1'b1; n++) @(negedge clk);
        `CHK({trap.valid, trap.vector}, {1'b1, scp_pkg::VEC_SLAVE})
        `CHK(trap.psw_push, 16'h0703)
        @(negedge clk);
        `CHK({psw, rd_cnt}, {16'h0001, k})
        $display("test quit finished");
    endtask : t_quit
    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : final_report
    initial begin
        #200000;
        errors++;
        final_report();
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_undef();
        t_exchange();
        t_loadreg();
        t_quit();
        final_report();
    end
endmodule : tb_slave_coprocessor_protocol
`default_nettype wire
